// File: verification/gbcd_bus_ctrl.sv
// Bus controller model: owns ATN, IFC, REN, EOI and the data lines
// Assumes the acceptor handshake is folded into one strobe per byte
`timescale 1ns/10ps
module gbcd_bus_ctrl (
	// Clock
	input  wire logic       ref_clk,
	// Lines owned by the controller, active low except byteStrobe
	output logic            atn_b,
	output logic            ifc_b,
	output logic            ren_b,
	output logic            eoiIn_b,
	output logic [7:0]      dio_b,
	output logic            byteStrobe,
	// Service request wire
	input  wire logic       srqOe,
	output logic            srqIn_b
);
	// Open drain wire with pull-up
	assign srqIn_b = srqOe ? 1'b0 : 1'b1;

	initial begin
		atn_b = 1'b1;
		ifc_b = 1'b1;
		ren_b = 1'b1;
		eoiIn_b = 1'b1;
		dio_b = 8'hFF;
		byteStrobe = 1'b0;
	end

	task lines(input logic ifc, input logic ren);
		@(posedge ref_clk);
		ifc_b <= ~ifc;
		ren_b <= ~ren;
	endtask

	task send(input logic atn, input logic eoi, input logic [7:0] b);
		@(posedge ref_clk);
		atn_b <= ~atn;
		eoiIn_b <= ~eoi;
		dio_b <= ~b;
		repeat (3) @(posedge ref_clk);
		byteStrobe <= 1'b1;
		@(posedge ref_clk);
		byteStrobe <= 1'b0;
		// Byte withdrawn: show its inverse
		dio_b <= b;
		eoiIn_b <= 1'b1;
	endtask
endmodule

// File: verification/gbcd_decoder_monitor.sv
// Concurrent checks on the bus command decoder ports
// Assumes one clock domain with synchronous active-low reset
`timescale 1ns/10ps
module gbcd_decoder_monitor (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_b,
	// Bus side inputs
	input  wire logic                 atn_b,
	input  wire logic                 ifc_b,
	input  wire logic                 eoiIn_b,
	input  wire logic [7:0]           dio_b,
	input  wire logic                 byteStrobe,
	input  wire logic [4:0]           primaryAddr,
	input  wire logic                 triggerOnUnaddr,
	input  wire logic                 serviceNeeded,
	// Watched outputs
	input  wire logic                 srqOe,
	input  wire gbcd_pkg::gbcd_byte_t dataOut,
	input  wire logic                 dataValid,
	input  wire logic                 dataLast,
	input  wire logic                 listenActive,
	input  wire logic                 talkActive,
	input  wire logic                 serialPoll,
	input  wire logic                 deviceClear,
	input  wire logic                 triggerPulse
);
	import gbcd_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Bytes taken: commands with ATN true, data bytes with ATN false
	// ----------------------------------------
	sequence s_cmd(logic [6:0] c);
		byteStrobe && !atn_b && ifc_b && (~dio_b[6:0]) == c ##1 ifc_b [*2];
	endsequence
	sequence s_scg;
		byteStrobe && !atn_b && ifc_b && (~dio_b[6:5]) == 2'b11 ##1 ifc_b [*2];
	endsequence
	sequence s_data;
		byteStrobe && atn_b && ifc_b && listenActive ##1 (ifc_b && listenActive) [*2];
	endsequence
	sequence s_sdc_unaddr;
		byteStrobe && !atn_b && (~dio_b[6:0]) == 7'h04 && !listenActive ##1 !listenActive [*2];
	endsequence

	a_mla_listen: assert property (s_cmd({2'b01, primaryAddr}) |=> listenActive)
		else $error("listen address not taken");
	a_mta_talk: assert property (s_cmd({2'b10, primaryAddr}) |=> talkActive && !listenActive)
		else $error("talk address not taken");
	a_unl_idle: assert property (s_cmd(7'h3F) |=> !listenActive)
		else $error("unlisten ignored");
	a_unt_idle: assert property (s_cmd(7'h5F) |=> !talkActive)
		else $error("untalk ignored");
	a_spe_enter: assert property (s_cmd(7'h18) |=> serialPoll)
		else $error("poll enable ignored");
	a_dcl_pulse: assert property (s_cmd(7'h14) |=> deviceClear)
		else $error("device clear missing");
	a_get_pulse: assert property (s_cmd(7'h08) ##0 triggerOnUnaddr |=> triggerPulse)
		else $error("trigger missing");
	a_scg_inert: assert property (s_scg |=> $stable(listenActive) && $stable(talkActive) && $stable(serialPoll))
		else $error("secondary byte changed state");
	a_cmd_no_data: assert property (byteStrobe && !atn_b |-> ##3 !dataValid)
		else $error("command passed as data");
	a_data_valid: assert property (s_data |=> dataValid)
		else $error("data byte lost");
	a_data_byte: assert property (dataValid |-> dataOut == ~$past(dio_b, 3) && dataLast == !$past(eoiIn_b, 3))
		else $error("data byte or end mark wrong");
	a_sdc_unaddr: assert property (s_sdc_unaddr |=> !deviceClear)
		else $error("unaddressed clear acted");
	a_ifc_idle: assert property ($fell(ifc_b) ##1 !ifc_b [*3] |=> !listenActive && !talkActive && !serialPoll)
		else $error("interface clear ignored");
	a_srq_set: assert property (serviceNeeded |=> srqOe)
		else $error("service request not raised");
endmodule

bind gbcd_decoder gbcd_decoder_monitor gbcd_decoder_monitor_inst (
	.ref_clk (ref_clk), .rst_b (rst_b), .atn_b (atn_b), .ifc_b (ifc_b), .eoiIn_b (eoiIn_b),
	.dio_b (dio_b), .byteStrobe (byteStrobe), .primaryAddr (primaryAddr),
	.triggerOnUnaddr (triggerOnUnaddr), .serviceNeeded (serviceNeeded), .srqOe (srqOe),
	.dataOut (dataOut), .dataValid (dataValid), .dataLast (dataLast), .listenActive (listenActive),
	.talkActive (talkActive), .serialPoll (serialPoll), .deviceClear (deviceClear),
	.triggerPulse (triggerPulse)
);

// File: verification/tb_gbcd_decoder.sv
// Testbench for the bus command decoder
// Assumes the controller model drives every bus line
`timescale 1ns/10ps
module tb_gbcd_decoder;
	import gbcd_pkg::*;
	logic       ref_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       lockOnRen = 1'b1;
	logic       triggerOnUnaddr = 1'b1;
	logic       serviceNeeded = 1'b0;
	logic       serviceDone = 1'b0;
	logic [4:0] primaryAddr = 5'h16;
	logic       atn_b, ifc_b, ren_b, eoiIn_b, srqIn_b, byteStrobe, srqOut, srqOe;
	logic [7:0] dio_b;
	gbcd_byte_t dataOut;
	logic       dataValid, dataLast, listenActive, talkActive, serialPoll, remoteMode;
	logic       localLockout, panelLocked, deviceClear, triggerPulse, srqLine;
	int         err_count = 0;
	int         check_count = 0;
	int         i;
	logic [7:0] noop [7] = '{8'h60, 8'h6A, 8'h7F, 8'h05, 8'h15, 8'h09, 8'h1F};

	always #50 ref_clk = ~ref_clk;

	gbcd_bus_ctrl gbcd_bus_ctrl_inst (
		.ref_clk (ref_clk), .atn_b (atn_b), .ifc_b (ifc_b), .ren_b (ren_b), .eoiIn_b (eoiIn_b),
		.dio_b (dio_b), .byteStrobe (byteStrobe), .srqOe (srqOe), .srqIn_b (srqIn_b)
	);
	gbcd_decoder gbcd_decoder_inst (
		.ref_clk (ref_clk), .rst_b (rst_b), .atn_b (atn_b), .ifc_b (ifc_b), .ren_b (ren_b),
		.eoiIn_b (eoiIn_b), .srqIn_b (srqIn_b), .srqOut (srqOut), .srqOe (srqOe), .dio_b (dio_b),
		.byteStrobe (byteStrobe), .primaryAddr (primaryAddr), .lockOnRen (lockOnRen),
		.triggerOnUnaddr (triggerOnUnaddr), .serviceNeeded (serviceNeeded), .serviceDone (serviceDone),
		.dataOut (dataOut), .dataValid (dataValid), .dataLast (dataLast), .listenActive (listenActive),
		.talkActive (talkActive), .serialPoll (serialPoll), .remoteMode (remoteMode),
		.localLockout (localLockout), .panelLocked (panelLocked), .deviceClear (deviceClear),
		.triggerPulse (triggerPulse), .srqLine (srqLine)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chkB(input logic g, input logic e, input string m);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task chkY(input logic [7:0] g, input logic [7:0] e, input string m);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic waitSig(ref logic s, input logic v);
		int n;
		check_count++;
		for (n = 0; n < 10 && s !== v; n++) begin
			@(posedge ref_clk);
			#1;
		end
		#1;
		if (s !== v) begin
			err_count++;
			$display("[FAIL] %0t wait ran out", $time);
			test_done();
		end
	endtask

	// Byte on the bus; pulses stand just after the second edge past the strobe
	task cmd(input logic [7:0] b, input logic at = 1'b1, input logic eo = 1'b0);
		gbcd_bus_ctrl_inst.send(at, eo, b);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chkB(listenActive | talkActive | serialPoll | remoteMode | srqOe, 1'b0, "reset");
		$display("test reset done");
		gbcd_bus_ctrl_inst.lines(1'b0, 1'b1);
		waitSig(remoteMode, 1'b1);
		cmd(8'h21);
		chkB(listenActive, 1'b0, "other lag");
		cmd(8'hB6);
		chkB(listenActive, 1'b1, "my lag");
		chkB(dataValid, 1'b0, "cmd as data");
		chkB(remoteMode, 1'b1, "remote");
		chkB(panelLocked & ~localLockout, 1'b1, "ren lock");
		cmd(8'h2A, 1'b0);
		chkY(dataOut, 8'h2A, "data");
		chkB(dataValid & ~dataLast, 1'b1, "valid");
		cmd(8'h54, 1'b0, 1'b1);
		chkB(dataLast, 1'b1, "last");
		$display("test address and data done");
		for (i = 0; i < 7; i++) begin
			cmd(noop[i]);
			chkB(listenActive & remoteMode & ~talkActive & ~serialPoll, 1'b1, "inert state");
			chkB(deviceClear | triggerPulse | dataValid, 1'b0, "inert pulse");
		end
		$display("test inert bytes done");
		cmd(8'h04);
		chkB(deviceClear, 1'b1, "sdc");
		cmd(8'h11);
		chkB(localLockout & panelLocked, 1'b1, "llo");
		cmd(8'h36);
		cmd(8'h01);
		chkB(remoteMode, 1'b0, "gtl");
		cmd(8'h56);
		chkB(talkActive & ~listenActive, 1'b1, "mta");
		cmd(8'h5F);
		chkB(talkActive, 1'b0, "unt");
		cmd(8'h36);
		cmd(8'h3F);
		chkB(listenActive, 1'b0, "unl");
		chkB(remoteMode, 1'b1, "remote again");
		cmd(8'h04);
		chkB(deviceClear, 1'b0, "sdc unaddr");
		cmd(8'h01);
		chkB(remoteMode, 1'b1, "gtl unaddr");
		cmd(8'h2A, 1'b0);
		chkB(dataValid, 1'b0, "data unaddr");
		cmd(8'h14);
		chkB(deviceClear, 1'b1, "dcl");
		cmd(8'h08);
		chkB(triggerPulse, 1'b1, "get");
		@(posedge ref_clk);
		triggerOnUnaddr <= 1'b0;
		cmd(8'h08);
		chkB(triggerPulse, 1'b0, "get unaddr");
		cmd(8'h18);
		chkB(serialPoll, 1'b1, "spe");
		cmd(8'h19);
		chkB(serialPoll, 1'b0, "spd");
		$display("test commands done");
		cmd(8'h18);
		cmd(8'h36);
		gbcd_bus_ctrl_inst.lines(1'b1, 1'b1);
		waitSig(listenActive, 1'b0);
		chkB(serialPoll | talkActive, 1'b0, "ifc");
		gbcd_bus_ctrl_inst.lines(1'b0, 1'b0);
		waitSig(remoteMode, 1'b0);
		chkB(localLockout, 1'b0, "ren off");
		$display("test clear and remote done");
		@(posedge ref_clk);
		serviceNeeded <= 1'b1;
		@(posedge ref_clk);
		serviceNeeded <= 1'b0;
		waitSig(srqLine, 1'b1);
		repeat (5) @(posedge ref_clk);
		#1;
		chkB(srqOe & ~srqOut, 1'b1, "srq held");
		@(posedge ref_clk);
		serviceDone <= 1'b1;
		@(posedge ref_clk);
		serviceDone <= 1'b0;
		waitSig(srqOe, 1'b0);
		$display("test service request done");
		test_done();
	end
endmodule

// File: verilog/gbcd_classify.sv
// Combinational classifier of a command byte against the primary address
// Assumes byte already inverted to positive logic
`timescale 1ns/10ps
`include "gbcd_defs.svh"
module gbcd_classify (
	// Byte and address
	input  wire logic [7:0] cmdByte,
	input  wire logic [4:0] primaryAddr,
	// Decoded strobes
	output logic            isGtl,
	output logic            isSdc,
	output logic            isGet,
	output logic            isLlo,
	output logic            isDcl,
	output logic            isSpe,
	output logic            isSpd,
	output logic            isUnl,
	output logic            isUnt,
	output logic            isMla,
	output logic            isOta,
	output logic            isMta,
	output logic            isOla
);

	logic [6:0] b7;
	logic [1:0] grp;

	// DIO8 is don't care for command bytes
	assign b7    = cmdByte[6:0];
	assign grp   = b7[6:5];
	assign isGtl = ({1'b0, b7} == `GBCD_CMD_GTL);
	assign isSdc = ({1'b0, b7} == `GBCD_CMD_SDC);
	assign isGet = ({1'b0, b7} == `GBCD_CMD_GET);
	assign isLlo = ({1'b0, b7} == `GBCD_CMD_LLO);
	assign isDcl = ({1'b0, b7} == `GBCD_CMD_DCL);
	assign isSpe = ({1'b0, b7} == `GBCD_CMD_SPE);
	assign isSpd = ({1'b0, b7} == `GBCD_CMD_SPD);
	assign isUnl = ({1'b0, b7} == `GBCD_CMD_UNL);
	assign isUnt = ({1'b0, b7} == `GBCD_CMD_UNT);
	assign isMla = ({1'b0, b7} == (`GBCD_LISTEN_OR | {3'b000, primaryAddr})) && !isUnl;
	assign isMta = ({1'b0, b7} == (`GBCD_TALK_OR | {3'b000, primaryAddr})) && !isUnt;
	assign isOta = (grp == `GBCD_GRP_TAG) && !isMta && !isUnt;
	assign isOla = (grp == `GBCD_GRP_LAG) && !isMla && !isUnl;

endmodule

// File: verilog/gbcd_decoder.sv
// Bus command decoder: uniline monitor and multiline command interpreter
// Assumes bus pins are raw active-low levels; byte strobe comes from the
// acceptor handshake on ref_clk, one cycle per accepted byte
`timescale 1ns/10ps
`include "gbcd_defs.svh"
module gbcd_decoder (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	// Bus management lines, active low from pins
	input  wire logic                atn_b,
	input  wire logic                ifc_b,
	input  wire logic                ren_b,
	input  wire logic                eoiIn_b,
	// Service request pin, open drain
	input  wire logic                srqIn_b,
	output logic                     srqOut,
	output logic                     srqOe,
	// Accepted byte from acceptor handshake
	input  wire logic [7:0]          dio_b,
	input  wire logic                byteStrobe,
	// Configuration
	input  wire logic [4:0]          primaryAddr,
	input  wire logic                lockOnRen,
	input  wire logic                triggerOnUnaddr,
	// Device side events
	input  wire logic                serviceNeeded,
	input  wire logic                serviceDone,
	// Data path
	output gbcd_pkg::gbcd_byte_t     dataOut,
	output logic                     dataValid,
	output logic                     dataLast,
	// State and command outputs
	output logic                     listenActive,
	output logic                     talkActive,
	output logic                     serialPoll,
	output logic                     remoteMode,
	output logic                     localLockout,
	output logic                     panelLocked,
	output logic                     deviceClear,
	output logic                     triggerPulse,
	output logic                     srqLine
);
	import gbcd_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [12:0] pinsSync;
	logic        atnTrue;
	logic        ifcTrue;
	logic        renTrue;
	logic        eoiTrue;
	logic        srqSeen;
	logic [7:0]  busByte;

	gbcd_sync #(.WIDTH(13)) uSync (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.asyncIn (~{atn_b, ifc_b, ren_b, eoiIn_b, srqIn_b, dio_b}),
		.syncOut (pinsSync)
	);

	// Each line read from its own level only
	assign atnTrue = pinsSync[12];
	assign ifcTrue = pinsSync[11];
	assign renTrue = pinsSync[10];
	assign eoiTrue = pinsSync[9];
	assign srqSeen = pinsSync[8];
	assign busByte = pinsSync[7:0];

	// Strobe comes from same-clock logic; delay to meet synchronised data
	logic strobeD1_reg;
	logic strobeD2_reg;
	logic strobe;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			strobeD1_reg <= 1'b0;
			strobeD2_reg <= 1'b0;
		end else begin
			strobeD1_reg <= byteStrobe;
			strobeD2_reg <= strobeD1_reg;
		end
	end
	assign strobe = strobeD2_reg;

	// ----------------------------------------
	// Command classification
	// ----------------------------------------
	logic isGtl;
	logic isSdc;
	logic isGet;
	logic isLlo;
	logic isDcl;
	logic isSpe;
	logic isSpd;
	logic isUnl;
	logic isUnt;
	logic isMla;
	logic isOta;
	logic isMta;
	logic isOla;

	gbcd_classify uClass (
		.cmdByte     (busByte),
		.primaryAddr (primaryAddr),
		.isGtl       (isGtl),
		.isSdc       (isSdc),
		.isGet       (isGet),
		.isLlo       (isLlo),
		.isDcl       (isDcl),
		.isSpe       (isSpe),
		.isSpd       (isSpd),
		.isUnl       (isUnl),
		.isUnt       (isUnt),
		.isMla       (isMla),
		.isOta       (isOta),
		.isMta       (isMta),
		.isOla       (isOla)
	);

	logic cmdTake;
	logic dataTake;
	logic listenOk;
	logic renEdge;
	logic renPrev_reg;

	assign cmdTake  = strobe && atnTrue;
	assign dataTake = strobe && !atnTrue;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			renPrev_reg <= 1'b0;
		end else begin
			renPrev_reg <= renTrue;
		end
	end
	assign renEdge = renTrue && !renPrev_reg;

	// ----------------------------------------
	// Listener function
	// ----------------------------------------
	gbcd_listen_e listen_reg;
	gbcd_listen_e listen_next;

	always_comb begin
		listen_next = listen_reg;
		unique case (listen_reg)
			GBCD_LISTEN_IDLE: begin
				if (cmdTake && isMla) begin
					listen_next = GBCD_LISTEN_ADDR;
				end
			end
			GBCD_LISTEN_ADDR: begin
				if (cmdTake && isUnl) begin
					listen_next = GBCD_LISTEN_IDLE;
				end else if (cmdTake && isMta) begin
					listen_next = GBCD_LISTEN_IDLE;
				end
			end
			default: begin
				listen_next = GBCD_LISTEN_IDLE;
			end
		endcase
		if (ifcTrue) begin
			listen_next = GBCD_LISTEN_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			listen_reg <= GBCD_LISTEN_IDLE;
		end else begin
			listen_reg <= listen_next;
		end
	end
	assign listenOk = (listen_reg == GBCD_LISTEN_ADDR);

	// ----------------------------------------
	// Talker function and serial poll
	// ----------------------------------------
	gbcd_talk_e talk_reg;
	gbcd_talk_e talk_next;
	logic       spoll_reg;

	always_comb begin
		talk_next = talk_reg;
		unique case (talk_reg)
			GBCD_TALK_IDLE: begin
				if (cmdTake && isMta) begin
					talk_next = GBCD_TALK_ADDR;
				end
			end
			GBCD_TALK_ADDR,
			GBCD_TALK_SPOLL: begin
				if (cmdTake && (isUnt || isOta || isMla)) begin
					talk_next = GBCD_TALK_IDLE;
				end else if (spoll_reg) begin
					talk_next = GBCD_TALK_SPOLL;
				end else begin
					talk_next = GBCD_TALK_ADDR;
				end
			end
			default: begin
				talk_next = GBCD_TALK_IDLE;
			end
		endcase
		if (ifcTrue) begin
			talk_next = GBCD_TALK_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			talk_reg <= GBCD_TALK_IDLE;
		end else begin
			talk_reg <= talk_next;
		end
	end

	// Serial poll mode, universal so no addressing needed
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			spoll_reg <= 1'b0;
		end else if (ifcTrue) begin
			spoll_reg <= 1'b0;
		end else if (cmdTake && isSpe) begin
			spoll_reg <= 1'b1;
		end else if (cmdTake && isSpd) begin
			spoll_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Remote, local and lockout
	// ----------------------------------------
	logic remote_reg;
	logic llo_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			remote_reg <= 1'b0;
		end else if (!renTrue) begin
			remote_reg <= 1'b0;
		end else if (cmdTake && isGtl && listenOk) begin
			remote_reg <= 1'b0;
		end else if (cmdTake && isMla) begin
			remote_reg <= 1'b1;
		end else if (renEdge) begin
			remote_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			llo_reg <= 1'b0;
		end else if (!renTrue) begin
			llo_reg <= 1'b0;
		end else if (cmdTake && isLlo) begin
			llo_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Device clear and trigger pulses
	// ----------------------------------------
	logic clear_reg;
	logic trig_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			clear_reg <= 1'b0;
		end else begin
			clear_reg <= cmdTake && (isDcl || (isSdc && listenOk));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			trig_reg <= 1'b0;
		end else begin
			trig_reg <= cmdTake && isGet && (listenOk || triggerOnUnaddr);
		end
	end

	// ----------------------------------------
	// Data path
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			dataOut   <= 8'h00;
			dataValid <= 1'b0;
			dataLast  <= 1'b0;
		end else begin
			dataValid <= dataTake && listenOk;
			dataLast  <= dataTake && listenOk && eoiTrue;
			if (dataTake && listenOk) begin
				dataOut <= busByte;
			end
		end
	end

	// ----------------------------------------
	// Service request
	// ----------------------------------------
	logic srq_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			srq_reg <= 1'b0;
		end else if (serviceNeeded) begin
			srq_reg <= 1'b1;
		end else if (serviceDone || clear_reg) begin
			srq_reg <= 1'b0;
		end
	end

	// Open drain: pull low while requesting, never driven high
	assign srqOut  = 1'b0;
	assign srqOe   = srq_reg;
	assign srqLine = srqSeen;

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign listenActive = listenOk;
	assign talkActive   = (talk_reg != GBCD_TALK_IDLE);
	assign serialPoll   = spoll_reg;
	assign remoteMode   = remote_reg;
	assign localLockout = llo_reg;
	assign panelLocked  = llo_reg || (remote_reg && lockOnRen);
	assign deviceClear  = clear_reg;
	assign triggerPulse = trig_reg;

endmodule

// File: verilog/gbcd_defs.svh
// Constants for the bus command decoder: command codes, address ranges
// Assumes inclusion by bare name from design files
`ifndef GBCD_DEFS_SVH
`define GBCD_DEFS_SVH

// ----------------------------------------
// Multiline command codes
// ----------------------------------------
`define GBCD_CMD_GTL     8'h01
`define GBCD_CMD_SDC     8'h04
`define GBCD_CMD_GET     8'h08
`define GBCD_CMD_LLO     8'h11
`define GBCD_CMD_DCL     8'h14
`define GBCD_CMD_SPE     8'h18
`define GBCD_CMD_SPD     8'h19
`define GBCD_CMD_UNL     8'h3F
`define GBCD_CMD_UNT     8'h5F

// ----------------------------------------
// Address groups: top two bits of a 7-bit byte
// ----------------------------------------
`define GBCD_GRP_LAG     2'h1
`define GBCD_GRP_TAG     2'h2
`define GBCD_GRP_SCG     2'h3
`define GBCD_LISTEN_OR   8'h20
`define GBCD_TALK_OR     8'h40

// ----------------------------------------
// Timing
// ----------------------------------------
`define GBCD_CLK_NS      100
`define GBCD_CLEAR_NS    200
`define GBCD_CLEAR_CYC   ((`GBCD_CLEAR_NS + `GBCD_CLK_NS - 1) / `GBCD_CLK_NS)

`endif

// File: verilog/gbcd_pkg.sv
// Types for the bus command decoder
// Assumes the constants header is compiled alongside
package gbcd_pkg;

	typedef enum logic [1:0] {
		GBCD_LISTEN_IDLE = 2'b00,
		GBCD_LISTEN_ADDR = 2'b01
	} gbcd_listen_e;

	typedef enum logic [1:0] {
		GBCD_TALK_IDLE   = 2'b00,
		GBCD_TALK_ADDR   = 2'b01,
		GBCD_TALK_SPOLL  = 2'b10
	} gbcd_talk_e;

	typedef logic [7:0] gbcd_byte_t;

endpackage

// File: verilog/gbcd_sync.sv
// Two-flop synchroniser vector for bus pins
// Assumes inputs asynchronous to ref_clk
`timescale 1ns/10ps
module gbcd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// Data
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end

endmodule
